// [hw/break_address_match.sv]
/*
  One breakpoint comparator: matches a qualifying CPU access against a
  stored breakpoint address over the full address width.
  Assumes the access fields are stable for the cycle in which they are valid.
*/
`timescale 1ns/1ps

module break_address_match #(
  parameter int ADDR_WIDTH = 24
) (
  // Breakpoint setup.
  input wire logic [ADDR_WIDTH-1:0] break_addr_i,
  input wire logic enable_i,
  input wire logic on_fetch_i,
  input wire logic on_read_i,
  input wire logic on_write_i,
  // Access under test.
  input wire debug_unit_pkg::cpu_access_type access_i,
  // Result.
  output logic hit_o,
  output logic data_read_o
);

  logic addr_equal;
  logic qualified;

  // A hit needs the whole address and a kind of access that is enabled.
  assign addr_equal = (access_i.addr[ADDR_WIDTH-1:0] == break_addr_i);
  assign qualified = (access_i.fetch & on_fetch_i) | (access_i.read & on_read_i)
    | (access_i.write & on_write_i);
  assign hit_o = enable_i & addr_equal & qualified;
  assign data_read_o = access_i.read & on_read_i;

endmodule

// [hw/debug_break_control_unit.sv]
/*
  Debug break control unit: breakpoint registers, break qualifiers,
  single step, watchdog freeze, vector relocation, external abort gating and
  the break cause flags, reached only through the single-wire debug link.
  Assumes the link block delivers byte register requests synchronous to
  ref_clk_i, and that the CPU honours cpu_stall_o between instructions.
*/
`timescale 1ns/1ps

// Functional notes
// - First breakpoint address, three bytes, reset ones.
// - Second breakpoint address, three bytes, reset ones.
// - External break enable gates external break sources.
// - Break on write enables data write breaks.
// - Break on read enables data read breaks.
// - Three-bit breakpoint configuration field, bits 5-3.
// - Watchdog freeze halts watchdog while stalled.
// - Vector table from RAM or 8000h.
// - Abort disable ignores the external abort source.
// - External break flag, cleared with stall.
// - First breakpoint flag, cleared with stall.
// - Second breakpoint flag, cleared on monitor exit.
// - Direction flag captures read or write.
// - Reset flag set by reset, status 0x10.
// - Step flag, cleared with stall.
// - Step enable breaks after each instruction.
// - Writes to flags are ignored.
// - Registers reachable only over the debug link.
// - Stall bit halts CPU; clearing exits monitor.
module debug_break_control_unit #(
  parameter int ADDR_WIDTH = 24,
  parameter logic [23:0] VECTOR_RAM_BASE = 24'h000000
) (
  // Clock, reset and clock enable.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register requests from the debug link.
  input wire debug_unit_pkg::link_request_type link_req_i,
  input wire logic link_active_i,
  output logic [7:0] link_rdata_o,
  output logic link_ack_o,
  // CPU activity.
  input wire debug_unit_pkg::cpu_access_type cpu_access_i,
  input wire logic cpu_access_valid_i,
  input wire logic instr_done_i,
  // Product-specific sources and options.
  input wire logic ext_break_i,
  input wire logic ext_abort_i,
  input wire logic hw_watchdog_option_i,
  // Controls toward the core.
  output logic cpu_stall_o,
  output logic watchdog_freeze_o,
  output logic [23:0] vector_base_o,
  output logic [2:0] breakpoint_config_o
);

  // The breakpoint bytes sit in a 24-bit field; narrower buses compare only its low ADDR_WIDTH bits.
  generate
    if (ADDR_WIDTH < 1 || ADDR_WIDTH > debug_unit_pkg::ADDR_BITS) begin : g_bad_width
      $error("ADDR_WIDTH must lie between 1 and 24");
    end
  endgenerate

  // The read multiplexer and the cause flags are written out for exactly two
  // breakpoints, so any other count in the package is refused here.
  generate
    if (debug_unit_pkg::BREAK_COUNT != 2) begin : g_bad_count
      $error("BREAK_COUNT must be 2");
    end
  endgenerate

  // Register state.
  logic [debug_unit_pkg::BREAK_COUNT-1:0][23:0] break_addr;
  logic [7:0] control;
  logic [7:0] control_second;
  logic step_enable;
  logic ext_break_flag;
  logic first_break_flag;
  logic second_break_flag;
  logic direction_flag;
  logic reset_flag;
  logic step_flag;
  debug_unit_pkg::cpu_state_type cpu_state;
  logic after_reset;

  // Decoded request strobes.
  logic wr_req;
  logic wr_control;
  logic wr_control_second;
  logic wr_status;
  logic wr_stall;
  logic [7:0] wdata;

  assign wr_req = link_req_i.req & link_req_i.write;
  assign wdata = link_req_i.wdata;
  assign wr_control = wr_req & (link_req_i.addr == debug_unit_pkg::OFS_CONTROL);
  assign wr_control_second = wr_req
    & (link_req_i.addr == debug_unit_pkg::OFS_CONTROL_SECOND);
  assign wr_status = wr_req & (link_req_i.addr == debug_unit_pkg::OFS_STATUS);
  assign wr_stall = wr_req & (link_req_i.addr == debug_unit_pkg::OFS_STALL_CONTROL);

  // Named control fields.
  logic ext_break_enable;
  logic break_on_write_enable;
  logic break_on_read_enable;
  logic [2:0] breakpoint_config;
  logic watchdog_freeze;
  logic vector_table_in_ram;
  logic external_abort_disable;

  assign ext_break_enable = control[debug_unit_pkg::EXT_BREAK_ENABLE_BIT];
  assign break_on_write_enable = control[debug_unit_pkg::BREAK_ON_WRITE_BIT];
  assign break_on_read_enable = control[debug_unit_pkg::BREAK_ON_READ_BIT];
  assign breakpoint_config =
    control[debug_unit_pkg::BREAK_CONFIG_MSB:debug_unit_pkg::BREAK_CONFIG_LSB];
  assign watchdog_freeze = control[debug_unit_pkg::WATCHDOG_FREEZE_BIT];
  assign vector_table_in_ram = control_second[debug_unit_pkg::VECTOR_IN_RAM_BIT];
  assign external_abort_disable = control_second[debug_unit_pkg::EXT_ABORT_DISABLE_BIT];

  // Breakpoint byte registers, one generate loop over breakpoints and bytes.
  // The upper byte of each address sits at the lowest offset of its group.
  // Writes land byte by byte, so the host may see a half-updated address.
  genvar bp;
  genvar bt;
  generate
    for (bp = 0; bp < debug_unit_pkg::BREAK_COUNT; bp++) begin : g_break
      for (bt = 0; bt < debug_unit_pkg::BYTES_PER_BREAK; bt++) begin : g_byte
        localparam logic [3:0] OFS = 4'(bp * debug_unit_pkg::BYTES_PER_BREAK + bt);
        localparam int LSB = 8 * (debug_unit_pkg::BYTES_PER_BREAK - 1 - bt);
        logic wr_byte;
        assign wr_byte = wr_req & (link_req_i.addr == OFS);
        always_ff @(posedge ref_clk_i or posedge rst_i) begin
          if (rst_i) begin
            break_addr[bp][LSB+:8] <= debug_unit_pkg::BREAK_ADDR_RESET;
          end else if (ce_i && wr_byte) begin
            break_addr[bp][LSB+:8] <= wdata;
          end
        end
      end
    end
  endgenerate

  // Breakpoint comparators; configuration bits pick which ones are armed and
  // whether instruction fetches qualify.
  logic [debug_unit_pkg::BREAK_COUNT-1:0] break_hit;
  logic [debug_unit_pkg::BREAK_COUNT-1:0] break_read;

  generate
    for (bp = 0; bp < debug_unit_pkg::BREAK_COUNT; bp++) begin : g_match
      break_address_match #(
        .ADDR_WIDTH(ADDR_WIDTH)
      ) u_match (
        .break_addr_i(break_addr[bp][ADDR_WIDTH-1:0]),
        .enable_i(cpu_access_valid_i & breakpoint_config[bp]),
        .on_fetch_i(breakpoint_config[debug_unit_pkg::CFG_FETCH_BIT]),
        .on_read_i(break_on_read_enable),
        .on_write_i(break_on_write_enable),
        .access_i(cpu_access_i),
        .hit_o(break_hit[bp]),
        .data_read_o(break_read[bp])
      );
    end
  endgenerate

  // Direction of the hitting data access. Only a comparator that hit and was
  // qualified by a read reports a read, so a write hit always records zero.
  logic read_hit;
  assign read_hit = |(break_hit & break_read);

  // Break events; none is taken while the CPU is already stalled.
  logic running;
  logic ext_break_event;
  logic first_break_event;
  logic second_break_event;
  logic step_event;
  logic abort_event;
  logic data_break;
  logic any_break;

  assign running = (cpu_state == debug_unit_pkg::CPU_RUNNING);
  assign ext_break_event = running & link_active_i & ext_break_enable & ext_break_i;
  assign first_break_event = running & link_active_i & break_hit[0];
  assign second_break_event = running & link_active_i & break_hit[1];
  assign step_event = running & link_active_i & step_enable & instr_done_i;
  assign abort_event = running & link_active_i & ~external_abort_disable & ext_abort_i;
  assign data_break = (first_break_event | second_break_event)
    & (cpu_access_i.read | cpu_access_i.write) & ~cpu_access_i.fetch;
  assign any_break = ext_break_event | first_break_event | second_break_event
    | step_event | abort_event;

  // Stall control. A write of zero is the monitor exit and clears every flag except the direction flag.
  // Dropping the link forces the CPU to run, so a lost host cannot leave it
  // stalled for ever.
  logic monitor_exit;
  logic stall_set;
  debug_unit_pkg::cpu_state_type next_cpu_state;

  assign monitor_exit = wr_stall & ~wdata[debug_unit_pkg::STALL_BIT]
    & (cpu_state == debug_unit_pkg::CPU_STALLED);
  assign stall_set = any_break | (wr_stall & wdata[debug_unit_pkg::STALL_BIT])
    | (after_reset & link_active_i);

  always_comb begin
    next_cpu_state = cpu_state;
    if (!link_active_i) begin
      next_cpu_state = debug_unit_pkg::CPU_RUNNING;
    end else if (stall_set) begin
      next_cpu_state = debug_unit_pkg::CPU_STALLED;
    end else if (monitor_exit) begin
      next_cpu_state = debug_unit_pkg::CPU_RUNNING;
    end
  end

  // The reset state is caught one clock after release, not from the port.
  // Sampling the link at that first edge stalls the CPU right after reset,
  // which the reset flag then reports to the host.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_state <= debug_unit_pkg::CPU_RUNNING;
      after_reset <= 1'b1;
    end else if (ce_i) begin
      cpu_state <= next_cpu_state;
      after_reset <= 1'b0;
    end
  end

  // Control registers; reserved bits are never stored and read as zero.
  // Masking on write keeps the read-back clean even when a host forgets the
  // reserved bits.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      control <= debug_unit_pkg::CONTROL_RESET;
      control_second <= debug_unit_pkg::CONTROL_SECOND_RESET;
      step_enable <= debug_unit_pkg::STATUS_RESET[debug_unit_pkg::STEP_ENABLE_BIT];
    end else if (ce_i) begin
      if (wr_control) begin
        control <= wdata & 8'hBF;
      end
      if (wr_control_second) begin
        control_second <= wdata & 8'h03;
      end
      if (wr_status) begin
        step_enable <= wdata[debug_unit_pkg::STEP_ENABLE_BIT];
      end
    end
  end

  // Cause flags. Writes never reach them; a set in the clearing cycle wins.
  // Events are refused while stalled and the exit needs a stall, so the two
  // cannot meet in one cycle today; the order only matters if that changes.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_break_flag <= 1'b0;
      first_break_flag <= 1'b0;
      second_break_flag <= 1'b0;
      direction_flag <= 1'b0;
      reset_flag <= 1'b1;
      step_flag <= 1'b0;
    end else if (ce_i) begin
      ext_break_flag <= ext_break_event | (ext_break_flag & ~monitor_exit);
      first_break_flag <= first_break_event | (first_break_flag & ~monitor_exit);
      second_break_flag <= second_break_event | (second_break_flag & ~monitor_exit);
      reset_flag <= reset_flag & ~monitor_exit;
      step_flag <= step_event | (step_flag & ~monitor_exit);
      if (data_break) begin
        direction_flag <= read_hit;
      end
    end
  end

  // Status byte assembled from the flags.
  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[debug_unit_pkg::EXT_BREAK_FLAG_BIT] = ext_break_flag;
    status[debug_unit_pkg::FIRST_BREAK_FLAG_BIT] = first_break_flag;
    status[debug_unit_pkg::SECOND_BREAK_FLAG_BIT] = second_break_flag;
    status[debug_unit_pkg::DIRECTION_FLAG_BIT] = direction_flag;
    status[debug_unit_pkg::RESET_FLAG_BIT] = reset_flag;
    status[debug_unit_pkg::STEP_FLAG_BIT] = step_flag;
    status[debug_unit_pkg::STEP_ENABLE_BIT] = step_enable;
  end

  // Read multiplexer; unmapped offsets read zero.
  logic [7:0] read_value;
  always_comb begin
    case (link_req_i.addr)
      debug_unit_pkg::OFS_BREAK1_UPPER: read_value = break_addr[0][23:16];
      debug_unit_pkg::OFS_BREAK1_MIDDLE: read_value = break_addr[0][15:8];
      debug_unit_pkg::OFS_BREAK1_LOWER: read_value = break_addr[0][7:0];
      debug_unit_pkg::OFS_BREAK2_UPPER: read_value = break_addr[1][23:16];
      debug_unit_pkg::OFS_BREAK2_MIDDLE: read_value = break_addr[1][15:8];
      debug_unit_pkg::OFS_BREAK2_LOWER: read_value = break_addr[1][7:0];
      debug_unit_pkg::OFS_CONTROL: read_value = control;
      debug_unit_pkg::OFS_CONTROL_SECOND: read_value = control_second;
      debug_unit_pkg::OFS_STATUS: read_value = status;
      debug_unit_pkg::OFS_STALL_CONTROL: read_value = {4'h0, cpu_state, 3'h0};
      default: read_value = 8'h00;
    endcase
  end

  // Link answer: one-cycle acknowledge with registered read data.
  // Read data load only on reads, so a write in between never disturbs the
  // byte that the host fetched last.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_ack_o <= 1'b0;
      link_rdata_o <= 8'h00;
    end else if (ce_i) begin
      link_ack_o <= link_req_i.req;
      if (link_req_i.req && !link_req_i.write) begin
        link_rdata_o <= read_value;
      end
    end
  end

  // Core-facing outputs, registered. The watchdog freeze follows the stall
  // and is void when the hardware watchdog option is fixed on.
  // Registering them costs a cycle of latency but keeps decode glitches away
  // from the core.
  logic next_watchdog_freeze;
  logic [23:0] next_vector_base;

  assign next_watchdog_freeze = watchdog_freeze & ~hw_watchdog_option_i
    & (next_cpu_state == debug_unit_pkg::CPU_STALLED);
  assign next_vector_base = vector_table_in_ram ? VECTOR_RAM_BASE
    : debug_unit_pkg::VECTOR_ROM_BASE;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_stall_o <= 1'b0;
      watchdog_freeze_o <= 1'b0;
      vector_base_o <= debug_unit_pkg::VECTOR_ROM_BASE;
      breakpoint_config_o <= 3'h0;
    end else if (ce_i) begin
      cpu_stall_o <= (next_cpu_state == debug_unit_pkg::CPU_STALLED);
      watchdog_freeze_o <= next_watchdog_freeze;
      vector_base_o <= next_vector_base;
      breakpoint_config_o <= breakpoint_config;
    end
  end

endmodule

// [hw/debug_unit_pkg.sv]
/*
  Shared constants and types for the debug break control unit: register
  offsets, reset values, field positions and the packed carriers used on the
  CPU-side and link-side ports.
  Assumes the single-wire debug link decodes its own commands and presents
  byte-wide register requests with a four-bit register offset.
*/
package debug_unit_pkg;

  // Breakpoint address width and the byte registers that hold it.
  localparam int ADDR_BITS = 24;
  localparam int BREAK_COUNT = 2;
  localparam int BYTES_PER_BREAK = 3;

  // Register offsets as seen over the debug link.
  localparam logic [3:0] OFS_BREAK1_UPPER = 4'h0;
  localparam logic [3:0] OFS_BREAK1_MIDDLE = 4'h1;
  localparam logic [3:0] OFS_BREAK1_LOWER = 4'h2;
  localparam logic [3:0] OFS_BREAK2_UPPER = 4'h3;
  localparam logic [3:0] OFS_BREAK2_MIDDLE = 4'h4;
  localparam logic [3:0] OFS_BREAK2_LOWER = 4'h5;
  localparam logic [3:0] OFS_CONTROL = 4'h6;
  localparam logic [3:0] OFS_CONTROL_SECOND = 4'h7;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_STALL_CONTROL = 4'h9;

  // Values after reset.
  localparam logic [7:0] BREAK_ADDR_RESET = 8'hFF;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_SECOND_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h10;

  // Fields of the control register.
  localparam int EXT_BREAK_ENABLE_BIT = 0;
  localparam int BREAK_ON_WRITE_BIT = 1;
  localparam int BREAK_ON_READ_BIT = 2;
  localparam int BREAK_CONFIG_LSB = 3;
  localparam int BREAK_CONFIG_MSB = 5;
  localparam int WATCHDOG_FREEZE_BIT = 7;

  // Fields of the second control register.
  localparam int VECTOR_IN_RAM_BIT = 0;
  localparam int EXT_ABORT_DISABLE_BIT = 1;

  // Fields of the status register.
  localparam int EXT_BREAK_FLAG_BIT = 0;
  localparam int FIRST_BREAK_FLAG_BIT = 1;
  localparam int SECOND_BREAK_FLAG_BIT = 2;
  localparam int DIRECTION_FLAG_BIT = 3;
  localparam int RESET_FLAG_BIT = 4;
  localparam int STEP_FLAG_BIT = 5;
  localparam int STEP_ENABLE_BIT = 6;

  // Stall bit inside the stall control register.
  localparam int STALL_BIT = 3;

  // Breakpoint configuration bits: enable of each breakpoint, fetch match.
  localparam int CFG_BREAK1_ON_BIT = 0;
  localparam int CFG_BREAK2_ON_BIT = 1;
  localparam int CFG_FETCH_BIT = 2;

  // Vector table base in program memory.
  localparam logic [23:0] VECTOR_ROM_BASE = 24'h008000;

  // CPU run state.
  typedef enum logic {
    CPU_RUNNING = 1'b0,
    CPU_STALLED = 1'b1
  } cpu_state_type;

  // One CPU bus access, as offered for breakpoint comparison.
  typedef struct packed {
    logic [23:0] addr;
    logic fetch;
    logic read;
    logic write;
  } cpu_access_type;

  // One register request from the debug link.
  typedef struct packed {
    logic req;
    logic write;
    logic [3:0] addr;
    logic [7:0] wdata;
  } link_request_type;

endpackage

// [sim/debug_break_control_unit_assertions.sv]
/*
  Port-level checker for the debug break control unit, bound to its top.
  Assumes one clock, ref_clk_i, and an asynchronous active-high reset.
*/
`timescale 1ns/1ps

module debug_break_control_unit_assertions #(
  parameter logic [23:0] VECTOR_RAM_BASE = 24'h000000
) (
  // Clock, reset and enable.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Debug link.
  input wire debug_unit_pkg::link_request_type link_req_i,
  input wire logic link_active_i,
  input wire logic link_ack_o,
  // Options and controls.
  input wire logic hw_watchdog_option_i,
  input wire logic cpu_stall_o,
  input wire logic watchdog_freeze_o,
  input wire logic [23:0] vector_base_o,
  input wire logic [2:0] breakpoint_config_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // Decoded requests; a request only counts when the enable lets it be taken.
  wire take = ce_i && link_req_i.req;
  wire stall_wr = take && link_req_i.write && (link_req_i.addr == 4'h9);
  wire cfg_wr = take && link_req_i.write && (link_req_i.addr == 4'h6);

  property p_ack; take |=> link_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("request not acknowledged");
  property p_hold; cpu_stall_o && !stall_wr && link_active_i |=> cpu_stall_o; endproperty
  a_hold: assert property (p_hold) else $error("stall dropped without exit write");
  property p_exit;
    stall_wr && !link_req_i.wdata[3] && cpu_stall_o |=> !cpu_stall_o;
  endproperty
  a_exit: assert property (p_exit) else $error("stall kept after exit write");
  property p_enter; stall_wr && link_req_i.wdata[3] && link_active_i |=> cpu_stall_o; endproperty
  a_enter: assert property (p_enter) else $error("stall write did not stall");
  property p_wdg_hw; hw_watchdog_option_i |=> !watchdog_freeze_o; endproperty
  a_wdg_hw: assert property (p_wdg_hw) else $error("freeze with hardware option");
  property p_wdg_run; !cpu_stall_o [*2] |-> !watchdog_freeze_o; endproperty
  a_wdg_run: assert property (p_wdg_run) else $error("freeze while running");
  property p_cfg;
    cfg_wr |-> ##2 breakpoint_config_o == $past(link_req_i.wdata[5:3], 2);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config field not updated");
  property p_cfg_only; $changed(breakpoint_config_o) |-> $past(cfg_wr, 2); endproperty
  a_cfg_only: assert property (p_cfg_only) else $error("config changed unasked");
  property p_vec;
    vector_base_o == debug_unit_pkg::VECTOR_ROM_BASE || vector_base_o == VECTOR_RAM_BASE;
  endproperty
  a_vec: assert property (p_vec) else $error("vector base out of range");
endmodule

bind debug_break_control_unit debug_break_control_unit_assertions #(
  .VECTOR_RAM_BASE(VECTOR_RAM_BASE)
) chk_u (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .ce_i(ce_i),
  .link_req_i(link_req_i),
  .link_active_i(link_active_i),
  .link_ack_o(link_ack_o),
  .hw_watchdog_option_i(hw_watchdog_option_i),
  .cpu_stall_o(cpu_stall_o),
  .watchdog_freeze_o(watchdog_freeze_o),
  .vector_base_o(vector_base_o),
  .breakpoint_config_o(breakpoint_config_o)
);

// [sim/debug_break_control_unit_tb.sv]
/*
  Self-checking bench for the debug break control unit.
  Assumes the host model drives the link and the checker is bound to the design.
*/
`timescale 1ns/1ps

module debug_break_control_unit_tb;
  localparam logic [23:0] RAM_BASE = 24'h001000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic link_active = 1'b1;
  logic hw_opt = 1'b0;
  logic [3:0] evt = 4'h0;
  debug_unit_pkg::cpu_access_type acc = '0;
  debug_unit_pkg::link_request_type link_req;
  logic [7:0] link_rdata;
  logic link_ack, cpu_stall, wdg_freeze, was_rd;
  logic [23:0] vec_base, bp1, bp2;
  logic [2:0] cfg;
  logic [7:0] b [6];
  logic [7:0] seed = 8'h0F;
  logic [7:0] exp_q [$];
  logic [39:0] r;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  // Rows: control, second control, status write, status, events, {target, read, stall}.
  // Control bit 6 is masked by the host, so it marks a fetch access instead.
  logic [39:0] rows [13] = '{40'h3E00000012, 40'h3F00000113, 40'h3B00000082, 40'h3F00000A83,
    40'h3F00000086, 40'h3D00000088, 40'h3F00000489, 40'h3F00406043, 40'h3F02000022, 40'h3F00000023,
    40'h6800000283, 40'h2F00000088, 40'h3700000082};

  always #4 clk = ~clk;

  debug_host_model host_u (.clk_i(clk), .link_req_o(link_req));

  debug_break_control_unit #(.VECTOR_RAM_BASE(RAM_BASE)) dut_u (
    .ref_clk_i(clk), .rst_i(rst), .ce_i(ce), .link_req_i(link_req),
    .link_active_i(link_active), .link_rdata_o(link_rdata), .link_ack_o(link_ack),
    .cpu_access_i(acc), .cpu_access_valid_i(evt[3]), .instr_done_i(evt[2]),
    .ext_break_i(evt[0]), .ext_abort_i(evt[1]), .hw_watchdog_option_i(hw_opt),
    .cpu_stall_o(cpu_stall), .watchdog_freeze_o(wdg_freeze), .vector_base_o(vec_base),
    .breakpoint_config_o(cfg));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, d);
  endtask

  // Reads note their expected byte; the monitor compares when the answer shows.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.xfer(1'b0, a, 8'h00);
  endtask

  task automatic pulse(input logic [3:0] e);
    @(negedge clk);
    evt = e;
    @(negedge clk);
    evt = 4'h0;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // Remember whether the request taken at this edge was a read.
  always @(posedge clk) was_rd <= link_req.req && !link_req.write;

  // Compare each read answer with the oldest note while the one-cycle ack stands.
  always @(negedge clk) begin
    if (link_ack === 1'b1 && was_rd === 1'b1) begin
      if (exp_q.size() == 0) chk(24'h1, 24'h0);
      else chk(link_rdata, exp_q.pop_front());
    end
  end

  // Cycle ceiling well above the few hundred cycles the sequence needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    do_reset();
    chk(cpu_stall, 1'b1);
    for (int i = 0; i < 6; i++) rd(i[3:0], 8'hFF);
    rd(4'h6, 8'h00);
    rd(4'h7, 8'h00);
    rd(4'h8, 8'h10);
    rd(4'hA, 8'h00);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      b[i] = seed;
      wr(i[3:0], b[i]);
    end
    for (int i = 0; i < 6; i++) rd(i[3:0], b[i]);
    bp1 = {b[0], b[1], b[2]};
    bp2 = {b[3], b[4], b[5]};
    wr(4'h6, 8'hFF);
    rd(4'h6, 8'hBF);
    chk(cfg, 3'b111);
    chk(wdg_freeze, 1'b1);
    hw_opt = 1'b1;
    repeat (2) @(negedge clk);
    chk(wdg_freeze, 1'b0);
    hw_opt = 1'b0;
    wr(4'h7, 8'h03);
    rd(4'h7, 8'h03);
    chk(vec_base, RAM_BASE);
    wr(4'h7, 8'h00);
    rd(4'h7, 8'h00);
    chk(vec_base, debug_unit_pkg::VECTOR_ROM_BASE);
    wr(4'h8, 8'hFF);
    rd(4'h8, 8'h50);
    wr(4'h8, 8'h00);
    wr(4'h9, 8'h00);
    rd(4'h8, 8'h00);
    chk(cpu_stall, 1'b0);
    for (int i = 0; i < 13; i++) begin
      r = rows[i];
      acc.fetch = r[38];
      wr(4'h6, r[39:32]);
      wr(4'h7, r[31:24]);
      wr(4'h8, r[23:16]);
      acc.addr = (r[3:2] == 2'd2) ? bp2 : bp1 ^ {22'h0, r[3:2]};
      acc.read = r[1];
      acc.write = !r[1];
      pulse(r[7:4]);
      chk(cpu_stall, r[0]);
      if (r[0]) begin
        rd(4'h8, r[15:8]);
        wr(4'h9, 8'h00);
        rd(4'h8, r[15:8] & 8'h48);
      end
    end
    ce = 1'b0;
    pulse(4'h1);
    chk(cpu_stall, 1'b0);
    wr(4'h7, 8'h01);
    ce = 1'b1;
    rd(4'h7, 8'h00);
    wr(4'h9, 8'h08);
    chk(cpu_stall, 1'b1);
    link_active = 1'b0;
    repeat (2) @(negedge clk);
    chk(cpu_stall, 1'b0);
    link_active = 1'b1;
    do_reset();
    chk(cpu_stall, 1'b1);
    rd(4'h8, 8'h10);
    rd(4'h2, 8'hFF);
    repeat (3) @(negedge clk);
    chk(24'(exp_q.size()), 24'h0);
    final_report();
  end
endmodule

// [sim/debug_host_model.sv]
/*
  Model of the external debug host tool issuing byte register requests.
  Assumes a request is taken on a rising edge and answered one cycle later.
*/
`timescale 1ns/1ps

module debug_host_model (
  // Clock.
  input wire logic clk_i,
  // Requests toward the debug unit.
  output debug_unit_pkg::link_request_type link_req_o
);
  // Start idle so nothing is taken during reset.
  initial link_req_o = '0;

  // One on-the-fly transfer. Idle fields are inverted so stale values never look valid.
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    logic [7:0] m;
    case (a)
      4'h6: m = 8'hBF;
      4'h7: m = 8'h03;
      4'h8: m = 8'h7F;
      4'h9: m = 8'hF9;
      default: m = 8'hFF;
    endcase
    @(negedge clk_i);
    link_req_o = {1'b1, w, a, d & m};
    @(posedge clk_i);
    @(negedge clk_i);
    link_req_o = {1'b0, ~link_req_o[12:0]};
  endtask
endmodule
